// [include/ccr_pkg.sv]
// package: register map, field layout, reset values and carriers for the counter/compare block
package ccr_pkg;

  localparam int unsigned AXI_ADDR_W = 8;
  localparam int unsigned AXI_DATA_W = 32;
  localparam int unsigned CNT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NUM_CH = 3;
  localparam int unsigned NUM_TMR = 2;
  localparam int unsigned CSEL_W = 3;
  localparam int unsigned PRE_W = 11;

  // byte address = {glob, timer, index, 2'b00}; timer 0 is timer1, timer 1 is timer3
  localparam logic [3:0] IDX_CNT_LO = 4'h0;
  localparam logic [3:0] IDX_CNT_HI = 4'h1;
  localparam logic [3:0] IDX_CMPA_LO = 4'h2;
  localparam logic [3:0] IDX_CMPA_HI = 4'h3;
  localparam logic [3:0] IDX_CMPB_LO = 4'h4;
  localparam logic [3:0] IDX_CMPB_HI = 4'h5;
  localparam logic [3:0] IDX_CMPC_LO = 4'h6;
  localparam logic [3:0] IDX_CMPC_HI = 4'h7;
  localparam logic [3:0] IDX_CTRL = 4'h8;
  localparam logic [3:0] IDX_FORCE = 4'h9;
  localparam logic [3:0] IDX_STATUS = 4'h0;
  localparam logic [3:0] IDX_MASK = 4'h1;

  // clock select field and prescale divisors
  localparam logic [CSEL_W-1:0] CSEL_STOP = 3'h0;
  localparam logic [CSEL_W-1:0] CSEL_DIV1 = 3'h1;
  localparam logic [CSEL_W-1:0] CSEL_DIV8 = 3'h2;
  localparam logic [CSEL_W-1:0] CSEL_DIV64 = 3'h3;
  localparam logic [CSEL_W-1:0] CSEL_DIV256 = 3'h4;
  localparam logic [CSEL_W-1:0] CSEL_DIV1024 = 3'h5;
  localparam logic [PRE_W-1:0] DIV_1 = 11'h001;
  localparam logic [PRE_W-1:0] DIV_8 = 11'h008;
  localparam logic [PRE_W-1:0] DIV_64 = 11'h040;
  localparam logic [PRE_W-1:0] DIV_256 = 11'h100;
  localparam logic [PRE_W-1:0] DIV_1024 = 11'h400;

  localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
  localparam logic [CNT_W-1:0] CMP_RESET = 16'h0000;
  localparam logic [BYTE_W-1:0] TEMP_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one write into a timer: count load or compare loads, all carrying the same 16-bit word
  typedef struct packed {
    logic countWr;
    logic [NUM_CH-1:0] cmpWr;
    logic [CNT_W-1:0] data;
  } ccr_wr_t;

  // decoded register address
  typedef struct packed {
    logic hit;
    logic glob;
    logic tmr;
    logic [3:0] idx;
  } ccr_dec_t;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP = 2'b10
  } ccr_wst_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } ccr_rst_t;

endpackage

// [core/ccr_prescaler.sv]
// prescaler that turns the system clock into timer ticks
module ccr_prescaler
  import ccr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [CSEL_W-1:0] clockSel,
  output logic tick
);

  logic [PRE_W-1:0] preCnt_r;
  logic tick_r;
  logic [PRE_W-1:0] divLast;

  // divisor for a clock select code; external-pin codes are not wired here and stop the timer
  function automatic logic [PRE_W-1:0] divOf(input logic [CSEL_W-1:0] sel);
    unique case (sel)
      CSEL_DIV1: divOf = DIV_1;
      CSEL_DIV8: divOf = DIV_8;
      CSEL_DIV64: divOf = DIV_64;
      CSEL_DIV256: divOf = DIV_256;
      CSEL_DIV1024: divOf = DIV_1024;
      default: divOf = '0;
    endcase
  endfunction

  assign divLast = divOf(clockSel) - 11'h001;

  // free-running divide counter, held at zero while stopped
  always_ff @(posedge clock) begin
    if (rst || divOf(clockSel) == '0) begin
      preCnt_r <= '0;
      tick_r <= 1'b0;
    end else if (preCnt_r >= divLast) begin
      preCnt_r <= '0;
      tick_r <= 1'b1;
    end else begin
      preCnt_r <= preCnt_r + 11'h001;
      tick_r <= 1'b0;
    end
  end

  assign tick = tick_r;

endmodule

// [core/ccr_timer.sv]
// one 16-bit counter with three compare units, match pulses and compare output pins
module ccr_timer
  import ccr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic tick,
  input wire ccr_wr_t wr,
  input wire logic [NUM_CH-1:0] forcedStrobe,
  output logic [CNT_W-1:0] countValue,
  output logic [NUM_CH-1:0][CNT_W-1:0] compareValue,
  output logic [NUM_CH-1:0] matchPulse,
  output logic [NUM_CH-1:0] comparePin
);

  logic [CNT_W-1:0] count_r;
  logic [NUM_CH-1:0][CNT_W-1:0] cmp_r;
  logic block_r;
  logic [NUM_CH-1:0] match_r;
  logic [NUM_CH-1:0] pin_r;
  logic [NUM_CH-1:0] matchNow;

  // a software load wins over the tick increment
  always_ff @(posedge clock) begin
    if (rst) count_r <= CNT_RESET;
    else if (wr.countWr) count_r <= wr.data; // [RL1]
    else if (tick) count_r <= count_r + 16'h0001;
  end

  // a count write arms a block that eats the compare on the next tick
  always_ff @(posedge clock) begin
    if (rst) block_r <= 1'b0;
    else if (wr.countWr) block_r <= 1'b1; // [RL4]
    else if (tick) block_r <= 1'b0;
  end

  // each channel keeps its own full-width compare word
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (rst) cmp_r[i] <= CMP_RESET;
      else if (wr.cmpWr[i]) cmp_r[i] <= wr.data; // [RL6]
    end
  end

  // compare is evaluated on the tick; the pulse lands one clock later
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      matchNow[i] = tick && !block_r && (count_r == cmp_r[i]); // [RL4]
    end
  end

  always_ff @(posedge clock) begin
    if (rst) match_r <= '0;
    else match_r <= matchNow; // [RL9]
  end

  // pin toggles on a real or forced compare; forcing never reaches the match pulse
  always_ff @(posedge clock) begin
    if (rst) pin_r <= '0;
    else pin_r <= pin_r ^ (matchNow | forcedStrobe); // [RL8] [RL10]
  end

  assign countValue = count_r;
  assign compareValue = cmp_r;
  assign matchPulse = match_r;
  assign comparePin = pin_r;

  a_match_blocked: assert property ( // [RL4]
    @(posedge clock) disable iff (rst) (tick && block_r) |=> (match_r == '0))
    else $error("compare matched on the tick right after a count write");

  a_match_follows: assert property ( // [RL9]
    @(posedge clock) disable iff (rst)
    (tick && !block_r && count_r == cmp_r[0]) |=> match_r[0])
    else $error("channel a match pulse missing one clock after equality");

  a_pin_toggle: assert property ( // [RL8]
    @(posedge clock) disable iff (rst)
    (matchNow != '0) |=> (((pin_r ^ $past(pin_r)) & $past(matchNow)) == $past(matchNow)))
    else $error("compare pin did not toggle on match");

endmodule

// [core/ccr_counter_compare_regs16.sv]
// counter and compare registers of two 16-bit timers behind an axi4-lite slave
//
// Function
// (RL1) The count of each timer is a high and a low byte location that software reads and writes.
// (RL2) Count accesses pass a shared high-byte holding register so both bytes move at once.
// (RL3) One holding register serves every 16-bit register of both timers.
// (RL4) A count write suppresses compare matches on all channels at the next timer tick.
// (RL5) Software should not change a running count, since a match may then be missed.
// (RL6) Every compare channel of both timers owns its own 16-bit compare register.
// (RL7) Compare writes go through the holding register so both bytes take effect together.
// (RL8) A match can raise an interrupt or toggle the channel's compare output pin.
// (RL9) A channel's match flag is set in the tick cycle after count equals its compare value.
// (RL10) A forced compare strobe does not set the forced channel's match flag.
// (RL11) Software writes high then low to commit, and reads low then high from the holding byte.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
module ccr_counter_compare_regs16
  import ccr_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic [AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AXI_DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [AXI_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic irq,
  output logic [NUM_CH-1:0] timer1ComparePin,
  output logic [NUM_CH-1:0] timer3ComparePin
);

  localparam int unsigned NUM_EV = NUM_TMR * NUM_CH;

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  ccr_wst_t wrState_r;
  ccr_rst_t rdState_r;
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic arready_r;
  logic rvalid_r;
  logic [1:0] rresp_r;
  logic [AXI_DATA_W-1:0] rdata_r;
  logic [AXI_ADDR_W-1:0] awAddr_r;
  logic [BYTE_W-1:0] wData_r;
  logic wStrb_r;
  logic [BYTE_W-1:0] temp_r;
  logic [CSEL_W-1:0] clockSel_r [NUM_TMR];
  logic [NUM_EV-1:0] status_r;
  logic [NUM_EV-1:0] status_nxt;
  logic [NUM_EV-1:0] mask_r;
  logic irq_r;

  ccr_dec_t wDec;
  ccr_dec_t rDec;
  logic doWrite;
  logic wrLive;
  logic readAccept;
  logic tempWrite;
  logic tempLatch;
  logic [BYTE_W-1:0] latchByte;
  logic [BYTE_W-1:0] rByte;
  logic [NUM_EV-1:0] statusClr;
  logic [CNT_W-1:0] commitWord;

  ccr_wr_t tmrWr [NUM_TMR];
  logic [NUM_CH-1:0] forceStrobe [NUM_TMR];
  logic tick [NUM_TMR];
  logic [CNT_W-1:0] cntVal [NUM_TMR];
  logic [NUM_CH-1:0][CNT_W-1:0] cmpVal [NUM_TMR];
  logic [NUM_CH-1:0] matchVec [NUM_TMR];
  logic [NUM_CH-1:0] pinVec [NUM_TMR];

  ////////////////////////////////////////////////////////////////////////////////
  // address decode, shared by the write and read sides

  function automatic ccr_dec_t decodeAddr(input logic [AXI_ADDR_W-1:0] a);
    ccr_dec_t d;
    d.glob = a[7];
    d.tmr = a[6];
    d.idx = a[5:2];
    if (a[1:0] != 2'b00) d.hit = 1'b0;
    else if (a[7]) d.hit = !a[6] && (a[5:2] <= IDX_MASK);
    else d.hit = (a[5:2] <= IDX_FORCE);
    return d;
  endfunction

  // compare channel addressed by a low or high compare index
  function automatic logic [1:0] cmpChan(input logic [3:0] idx);
    return 2'(idx[2:1] - 2'b01);
  endfunction

  assign wDec = decodeAddr(awAddr_r);
  assign rDec = decodeAddr(araddr);

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken in either order, then one response

  assign doWrite = (wrState_r == WR_COLLECT) && !awready_r && !wready_r;
  assign wrLive = doWrite && wDec.hit && wStrb_r;

  always_ff @(posedge clock) begin
    if (rst) begin
      wrState_r <= WR_COLLECT;
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      unique case (wrState_r)
        WR_COLLECT: begin
          if (awvalid && awready_r) awready_r <= 1'b0;
          if (wvalid && wready_r) wready_r <= 1'b0;
          if (doWrite) begin
            bvalid_r <= 1'b1;
            bresp_r <= wDec.hit ? RESP_OKAY : RESP_SLVERR;
            wrState_r <= WR_RESP;
          end
        end
        WR_RESP: begin
          if (bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            wrState_r <= WR_COLLECT;
          end
        end
      endcase
    end
  end

  // payload capture; only byte lane 0 carries data, other lanes are ignored
  always_ff @(posedge clock) begin
    if (rst) begin
      awAddr_r <= '0;
      wData_r <= '0;
      wStrb_r <= 1'b0;
    end else begin
      if (awvalid && awready_r) awAddr_r <= awaddr;
      if (wvalid && wready_r) begin
        wData_r <= wdata[BYTE_W-1:0];
        wStrb_r <= wstrb[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared high-byte holding register

  assign tempWrite = wrLive && !wDec.glob && wDec.idx[0] && (wDec.idx <= IDX_CMPC_HI);
  assign tempLatch = readAccept && rDec.hit && !rDec.glob && (rDec.idx == IDX_CNT_LO);
  assign latchByte = cntVal[rDec.tmr][CNT_W-1:BYTE_W];
  assign commitWord = {temp_r, wData_r};

  // a high-byte write beats a simultaneous low-count read latch
  always_ff @(posedge clock) begin
    if (rst) temp_r <= TEMP_RESET;
    else if (tempWrite) temp_r <= wData_r; // [RL2] [RL3] [RL7]
    else if (tempLatch) temp_r <= latchByte; // [RL2] [RL3]
  end

  // low-byte writes commit the held high byte with the new low byte in one clock
  always_comb begin
    for (int t = 0; t < NUM_TMR; t++) begin
      tmrWr[t] = '0;
      tmrWr[t].data = commitWord; // [RL2] [RL7]
      forceStrobe[t] = '0;
    end
    if (wrLive && !wDec.glob) begin
      unique case (wDec.idx)
        IDX_CNT_LO: tmrWr[wDec.tmr].countWr = 1'b1; // [RL1]
        IDX_CMPA_LO, IDX_CMPB_LO, IDX_CMPC_LO: begin
          tmrWr[wDec.tmr].cmpWr[cmpChan(wDec.idx)] = 1'b1; // [RL6] [RL7]
        end
        IDX_FORCE: forceStrobe[wDec.tmr] = wData_r[NUM_CH-1:0]; // [RL10]
        default: ;
      endcase
    end
  end

  // clock select per timer
  always_ff @(posedge clock) begin
    for (int t = 0; t < NUM_TMR; t++) begin
      if (rst) clockSel_r[t] <= CSEL_STOP;
      else if (wrLive && !wDec.glob && wDec.idx == IDX_CTRL && wDec.tmr == t[0]) begin
        clockSel_r[t] <= wData_r[CSEL_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // timers

  for (genvar g = 0; g < NUM_TMR; g++) begin : gTimer
    ccr_prescaler uPre (
      .clock(clock),
      .rst(rst),
      .clockSel(clockSel_r[g]),
      .tick(tick[g])
    );
    ccr_timer uTmr (
      .clock(clock),
      .rst(rst),
      .tick(tick[g]),
      .wr(tmrWr[g]),
      .forcedStrobe(forceStrobe[g]),
      .countValue(cntVal[g]),
      .compareValue(cmpVal[g]),
      .matchPulse(matchVec[g]),
      .comparePin(pinVec[g])
    );
  end

  assign timer1ComparePin = pinVec[0]; // [RL8]
  assign timer3ComparePin = pinVec[1];

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel: one read at a time, data one clock after acceptance

  assign readAccept = arvalid && arready_r;

  // read mux; the count high byte comes from the holding register, compares read directly
  always_comb begin
    rByte = '0;
    if (rDec.glob) begin
      if (rDec.idx == IDX_STATUS) rByte = 8'(status_r);
      else rByte = 8'(mask_r);
    end else begin
      unique case (rDec.idx)
        IDX_CNT_LO: rByte = cntVal[rDec.tmr][BYTE_W-1:0]; // [RL1]
        IDX_CNT_HI: rByte = temp_r; // [RL2]
        IDX_CMPA_LO, IDX_CMPB_LO, IDX_CMPC_LO: begin
          rByte = cmpVal[rDec.tmr][cmpChan(rDec.idx)][BYTE_W-1:0];
        end
        IDX_CMPA_HI, IDX_CMPB_HI, IDX_CMPC_HI: begin
          rByte = cmpVal[rDec.tmr][cmpChan(rDec.idx)][CNT_W-1:BYTE_W];
        end
        IDX_CTRL: rByte = 8'(clockSel_r[rDec.tmr]);
        default: rByte = '0;
      endcase
    end
    if (!rDec.hit) rByte = '0;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rdState_r <= RD_IDLE;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= '0;
    end else begin
      unique case (rdState_r)
        RD_IDLE: begin
          if (readAccept) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b1;
            rresp_r <= rDec.hit ? RESP_OKAY : RESP_SLVERR;
            rdata_r <= 32'(rByte);
            rdState_r <= RD_RESP;
          end
        end
        RD_RESP: begin
          if (rready) begin
            rvalid_r <= 1'b0;
            arready_r <= 1'b1;
            rdState_r <= RD_IDLE;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // match status, mask and interrupt

  // reading status clears it, but a match in the same clock survives
  always_comb begin
    statusClr = '0;
    if (readAccept && rDec.hit && rDec.glob && rDec.idx == IDX_STATUS) statusClr = '1;
    status_nxt = (status_r & ~statusClr) | {matchVec[1], matchVec[0]}; // [RL9]
  end

  always_ff @(posedge clock) begin
    if (rst) status_r <= '0;
    else status_r <= status_nxt;
  end

  always_ff @(posedge clock) begin
    if (rst) mask_r <= '0;
    else if (wrLive && wDec.glob && wDec.idx == IDX_MASK) mask_r <= wData_r[NUM_EV-1:0];
  end

  // registered level, one clock behind the status and mask
  always_ff @(posedge clock) begin
    if (rst) irq_r <= 1'b0;
    else irq_r <= |(status_r & mask_r); // [RL8]
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rresp = rresp_r;
  assign rdata = rdata_r;
  assign irq = irq_r;

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  a_temp_latch: assert property ( // [RL2]
    @(posedge clock) disable iff (rst)
    (tempLatch && !tempWrite) |=> (temp_r == $past(latchByte)))
    else $error("holding byte not latched by count low read");

  a_shared_temp: assert property ( // [RL3]
    @(posedge clock) disable iff (rst) tempWrite |=> (temp_r == $past(wData_r)))
    else $error("high byte write did not load the holding byte");

  a_count_commit: assert property ( // [RL1]
    @(posedge clock) disable iff (rst)
    (wrLive && !wDec.glob && !wDec.tmr && wDec.idx == IDX_CNT_LO)
    |=> (cntVal[0] == $past(commitWord)))
    else $error("count low write did not commit both bytes");

  a_low_commit: assert property ( // [RL7]
    @(posedge clock) disable iff (rst)
    (wrLive && !wDec.glob && wDec.tmr && wDec.idx == IDX_CMPB_LO)
    |=> (cmpVal[1][1] == $past(commitWord)))
    else $error("compare low write did not commit both bytes");

  a_force_no_flag: assert property ( // [RL10]
    @(posedge clock) disable iff (rst)
    (forceStrobe[0][0] && !matchVec[0][0] && !status_r[0]) |=> !status_r[0])
    else $error("forced strobe set a match flag");

  a_status_set: assert property ( // [RL9]
    @(posedge clock) disable iff (rst)
    (matchVec[0] != '0)
    |=> ((status_r[NUM_CH-1:0] & $past(matchVec[0])) == $past(matchVec[0])))
    else $error("match pulse did not set its status bit");

  a_irq_level: assert property ( // [RL8]
    @(posedge clock) disable iff (rst) (|(status_r & mask_r)) |=> irq_r)
    else $error("unmasked status did not raise the interrupt");

endmodule

// [verification/ccr_axi_master.sv]
// register bus master standing in for the processor core
module ccr_axi_master
  import ccr_pkg::*;
(
  input wire logic clock,
  output logic [AXI_ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [AXI_DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [AXI_ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [AXI_DATA_W-1:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // quiet bus at time zero; response readies stay high so back-to-back calls never
  // lower and raise them in one time step
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid} <= '0;
    {araddr, arvalid} <= '0;
    {bready, rready} <= 2'b11;
  end
  // one byte write; released payload is inverted so a stale value never looks valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= {24'h0, d};
    wstrb <= 4'h1;
    wvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~wdata;
      end
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask
  // one read, data taken at the edge that sees rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clock);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask
endmodule

// [verification/ccr_counter_compare_regs16_tb_top.sv]
// self-checking bench for the counter/compare register block
module ccr_counter_compare_regs16_tb_top
  import ccr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [AXI_DATA_W-1:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, irq;
  logic [NUM_CH-1:0] pin1, pin3;
  int num_errors = 0;
  int checked = 0;
  int cyc = 0;
  logic [15:0] cmpM [2][3];
  logic [7:0] holdM = 8'h00;
  always #4 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////
  ccr_counter_compare_regs16 dut_u (.clock(clock), .rst(rst), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .irq(irq), .timer1ComparePin(pin1), .timer3ComparePin(pin3));
  ccr_axi_master m_u (.clock(clock), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [7:0] ad(input logic t, input logic [3:0] i);
    return {1'b0, t, i, 2'b00};
  endfunction
  // write one byte and mirror the shared holding byte in the model
  task automatic w8(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    m_u.wr(a, d, r);
    chk("bresp", r, RESP_OKAY);
    if (!a[7] && a[5:2] < 4'h8 && a[2])
      holdM = d;
    else if (!a[7] && a[5:2] < 4'h8 && a[5:2] != 4'h0)
      cmpM[a[6]][int'(a[5:3]) - 1] = {holdM, d};
  endtask
  // software order: high byte first, the low byte commits
  task automatic w16(input logic t, input logic [3:0] i, input logic [15:0] v);
    w8(ad(t, i + 4'h1), v[15:8]);
    w8(ad(t, i), v[7:0]);
  endtask
  task automatic r8(input logic [7:0] a, output logic [31:0] d);
    logic [1:0] r;
    m_u.rd(a, d, r);
    chk("rresp", r, RESP_OKAY);
  endtask
  task automatic chk_cmp();
    logic [31:0] d;
    for (int t = 0; t < 2; t++) begin
      for (int c = 0; c < 3; c++) begin
        r8(ad(t[0], 4'(2 * c + 2)), d);
        chk("cmp low", d, {24'h0, cmpM[t][c][7:0]});
        r8(ad(t[0], 4'(2 * c + 3)), d);
        chk("cmp high", d, {24'h0, cmpM[t][c][15:8]});
      end
    end
  endtask
  task automatic run(input logic t, input logic [CSEL_W-1:0] cs, input int n);
    w8(ad(t, IDX_CTRL), {5'h0, cs});
    repeat (n) @(posedge clock);
    w8(ad(t, IDX_CTRL), {5'h0, CSEL_STOP});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  // main sequence
  initial begin
    logic [31:0] d, h;
    logic [1:0] r;
    void'($urandom(32'ha4279f41));
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    for (int k = 0; k < 16; k++) begin
      r8(ad(k[3], {1'b0, k[2:0]}), d);
      chk("reset value", d, 32'h0);
    end
    // random compares, high byte kept above the range the counters reach
    for (int k = 0; k < 6; k++)
      w16(k[0], 4'(2 * (k / 2) + 2), {8'($urandom_range(255, 32)), 8'($urandom)});
    chk_cmp();
    w8(ad(1'b0, IDX_CMPA_HI), 8'($urandom_range(255, 32)));
    w8(ad(1'b1, IDX_CMPB_LO), 8'($urandom));
    chk_cmp();
    w16(1'b1, IDX_CNT_LO, 16'h12f0);
    r8(ad(1'b1, IDX_CNT_LO), d);
    r8(ad(1'b1, IDX_CNT_HI), h);
    chk("count", {16'h0, h[7:0], d[7:0]}, 32'h12f0);
    w8(ad(1'b1, IDX_CTRL), {5'h0, CSEL_DIV1});
    r8(ad(1'b1, IDX_CNT_LO), d);
    repeat (3) @(posedge clock);
    r8(ad(1'b1, IDX_CNT_HI), h);
    chk("count latch", h, (d[7:0] >= 8'hf0) ? 32'h12 : 32'h13);
    w8(ad(1'b1, IDX_CTRL), {5'h0, CSEL_STOP});
    // count written only while stopped
    w16(1'b1, IDX_CMPA_LO, 16'h0005);
    w16(1'b1, IDX_CNT_LO, 16'h0005);
    run(1'b1, CSEL_DIV1, 10);
    r8(8'h80, d);
    chk("status", d, 32'h0);
    chk("pin3", pin3, 32'h0);
    w16(1'b0, IDX_CMPA_LO, 16'h0010);
    run(1'b0, CSEL_DIV1, 40);
    chk("irq masked", irq, 32'h0);
    chk("pin1", pin1, 32'h1);
    r8(8'h80, d);
    chk("status", d, 32'h1);
    r8(8'h80, d);
    chk("status cleared", d, 32'h0);
    w8(8'h84, 8'h01);
    r8(8'h84, d);
    chk("mask", d, 32'h1);
    w16(1'b0, IDX_CNT_LO, 16'h000c);
    run(1'b0, CSEL_DIV1, 20);
    chk("irq", irq, 32'h1);
    chk("pin1", pin1, 32'h0);
    r8(8'h80, d);
    chk("status", d, 32'h1);
    repeat (2) @(posedge clock);
    chk("irq cleared", irq, 32'h0);
    // force channels a and b, so the flag of a channel with a live compare is watched too
    w8(ad(1'b0, IDX_FORCE), 8'h03);
    repeat (2) @(posedge clock);
    chk("pin1 forced", pin1, 32'h3);
    r8(8'h80, d);
    chk("status forced", d, 32'h0);
    r8(ad(1'b0, IDX_FORCE), d);
    chk("force reads", d, 32'h0);
    // divide by 8: about 80/8 ticks; one count of slack for the unknown bus latency
    w16(1'b0, IDX_CNT_LO, 16'h0000);
    run(1'b0, CSEL_DIV8, 80);
    r8(ad(1'b0, IDX_CNT_LO), d);
    chk("div8 count", 32'(d[7:0] >= 8'h09 && d[7:0] <= 8'h0b), 32'h1);
    // unmapped and misaligned places
    m_u.wr(8'h28, 8'h55, r);
    chk("bresp bad", r, RESP_SLVERR);
    m_u.rd(8'h28, d, r);
    chk("rresp bad", r, RESP_SLVERR);
    chk("rdata bad", d, 32'h0);
    m_u.rd(8'h09, d, r);
    chk("rresp odd", r, RESP_SLVERR);
    chk_cmp();
    end_of_test();
  end
endmodule
